/* File: bench/adcs_core_model.sv */
/*
 * Behavioural analog core for the sequencer bench.
 * Assumes requests on ref_clk; done comes 20 cycles after start.
 */
`timescale 1ns/10ps
module adcs_core_model (
    input  wire logic                     ref_clk,
    input  wire logic                     rst_b,
    input  wire adcs_pkg::adcs_core_req_t req,
    input  wire logic [10:0]              rawVal,
    output adcs_pkg::adcs_core_rsp_t      rsp
);
    import adcs_pkg::*;
    int cnt;
    // abort or disable cancels the conversion in flight
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) cnt <= 0;
        else if (req.abort || !req.enable) cnt <= 0;
        else if (req.start) cnt <= 20;
        else if (cnt > 0) cnt <= cnt - 1;
    end
    // raw shows a changed value outside the done cycle
    assign rsp = {cnt == 1, (cnt == 1) ? rawVal : ~rawVal};
endmodule

/* File: bench/adcs_sequencer_bench.sv */
/*
 * Self-checking bench of the converter sequencer over Wishbone.
 * Assumes the core model answers 20 cycles after each start.
 */
`timescale 1ns/10ps
module adcs_sequencer_bench;
    import adcs_pkg::*;
    logic           ref_clk = 1'b0;
    logic           rst_b   = 1'b0;
    logic           cyc = 1'b0, stb = 1'b0, we = 1'b0, trig = 1'b0;
    logic           ack, irq, ok;
    logic [7:0]     adr = 8'h00, portIo = 8'h00, padIn = 8'h00, q;
    logic [7:0]     padOut, padOe, padPull, portRead;
    logic [31:0]    datI = 32'h0, datO;
    logic [10:0]    raw = 11'h000, e;
    adcs_core_req_t req;
    adcs_core_rsp_t rsp;
    int             n_errors = 0, n_tests = 0;
    always #5 ref_clk = ~ref_clk;
    adcs_sequencer u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
        .hw_trigger_input(trig), .alternate_clock(1'b0),
        .async_conv_clock(1'b0), .stopMode(1'b0), .coreReq(req),
        .coreRsp(rsp), .convIrq(irq), .portOut(portIo), .portOe(portIo),
        .portPullEn(portIo), .padIn(padIn), .padOut(padOut), .padOe(padOe),
        .padPullEn(padPull), .portRead(portRead));
    adcs_core_model u_core (.ref_clk(ref_clk), .rst_b(rst_b), .req(req),
        .rawVal(raw), .rsp(rsp));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // one classic cycle, entered just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        {cyc, stb, we, adr, datI} <= {2'b11, w, a, 24'h0, d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        ok = (ack === 1'b1);
        q = datO[7:0];
        {cyc, stb} <= 2'b00;
        @(posedge ref_clk);
        if (!ok) begin
            n_errors++;
            end_of_test();
        end
    endtask
    task automatic flag(input int lim, input logic exp);
        for (int i = 0; i < lim; i++) begin
            bus(1'b0, OFF_STATUS_CONTROL_1, 8'h00);
            if (q[7] === 1'b1) break;
        end
        chk({7'h0, q[7]}, {7'h0, exp});
    endtask
    // counts conversion clock ticks over 16 bus cycles
    task automatic ticks(input logic [7:0] exp);
        logic [7:0] t;
        t = 8'h00;
        repeat (16) begin
            @(posedge ref_clk);
            t = t + {7'h0, req.tick};
        end
        chk(t, exp);
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        bus(1'b0, OFF_STATUS_CONTROL_1, 8'h00);
        chk(q, {3'h0, CHAN_RESET});
        chk({7'h0, req.enable}, 8'h00);
        bus(1'b0, OFF_CONFIGURATION_REG, 8'h00);
        chk(q, {6'h0, CLK_BUS});
        bus(1'b0, 8'hFC, 8'h00);
        chk(q, 8'h00);
        $display("test reset done");
        portIo <= 8'hFF;
        padIn <= 8'hFF;
        bus(1'b1, OFF_ANALOG_PIN_DIS_3, 8'hA5);
        repeat (4) @(posedge ref_clk);
        chk(padOe, 8'h5A);
        chk(padPull, 8'h5A);
        chk(padOut, 8'hFF);
        chk(portRead, 8'h5A);
        $display("test pins done");
        raw <= 11'h2AB;
        e = (11'h2AB + 11'h001) >> 1;
        bus(1'b1, OFF_CONFIGURATION_REG, {3'h3, 1'b0, MODE_10BIT, CLK_BUS_HALF});
        ticks(8'h01);
        bus(1'b1, OFF_STATUS_CONTROL_1, 8'h42);
        flag(15, 1'b1);
        chk({7'h0, irq}, 8'h01);
        bus(1'b0, OFF_RESULT_HIGH, 8'h00);
        chk(q, {6'h0, e[9:8]});
        bus(1'b1, OFF_STATUS_CONTROL_1, 8'h02);
        flag(12, 1'b0);
        bus(1'b0, OFF_RESULT_LOW, 8'h00);
        chk(q, e[7:0]);
        flag(15, 1'b1);
        $display("test ten bit done");
        raw <= 11'h0FF;
        bus(1'b1, OFF_CONFIGURATION_REG, {4'h0, MODE_8BIT, CLK_BUS});
        ticks(8'h10);
        bus(1'b1, OFF_STATUS_CONTROL_1, 8'h03);
        flag(15, 1'b1);
        bus(1'b0, OFF_RESULT_LOW, 8'h00);
        chk(q, 8'h80);
        raw <= 11'h010;
        bus(1'b1, OFF_STATUS_CONTROL_1, 8'h03);
        bus(1'b1, OFF_COMPARE_VALUE_LOW, 8'h00);
        flag(12, 1'b0);
        bus(1'b0, OFF_RESULT_LOW, 8'h00);
        chk(q, 8'h80);
        bus(1'b1, OFF_STATUS_CONTROL_1, 8'h23);
        flag(15, 1'b1);
        bus(1'b0, OFF_RESULT_LOW, 8'h00);
        chk(q, 8'h08);
        flag(15, 1'b1);
        $display("test modes done");
        bus(1'b1, OFF_STATUS_CONTROL_2, 8'h40);
        bus(1'b1, OFF_STATUS_CONTROL_1, 8'h03);
        flag(10, 1'b0);
        trig <= 1'b1;
        flag(15, 1'b1);
        trig <= 1'b0;
        bus(1'b1, OFF_STATUS_CONTROL_1, 8'h1F);
        chk({7'h0, req.enable}, 8'h00);
        $display("test trigger done");
        end_of_test();
    end
endmodule

/* File: core/adcs_pkg.sv */
/*
 * Constants, register map, field layout and carrier types of the
 * converter sequencer. Assumes a 32-bit classic Wishbone register bus
 * with byte addresses and a successive approximation core outside.
 */
package adcs_pkg;
    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_STATUS_CONTROL_1   = 8'h00;
    localparam logic [7:0] OFF_STATUS_CONTROL_2   = 8'h04;
    localparam logic [7:0] OFF_RESULT_HIGH        = 8'h08;
    localparam logic [7:0] OFF_RESULT_LOW         = 8'h0C;
    localparam logic [7:0] OFF_COMPARE_VALUE_HIGH = 8'h10;
    localparam logic [7:0] OFF_COMPARE_VALUE_LOW  = 8'h14;
    localparam logic [7:0] OFF_CONFIGURATION_REG  = 8'h18;
    localparam logic [7:0] OFF_ANALOG_PIN_DIS_3   = 8'h1C;
    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int SC1_CONVERSION_COMPLETE_FLAG_BIT   = 7;
    localparam int SC1_IRQEN_BIT  = 6;
    localparam int SC1_CONT_BIT   = 5;
    localparam int SC2_ACTIVE_BIT = 7;
    localparam int SC2_HWSEL_BIT  = 6;
    localparam int SC2_CMPEN_BIT  = 5;
    localparam int SC2_CMPGT_BIT  = 4;
    localparam int CFG_DIV_LSB    = 5;
    localparam int CFG_MODE_LSB   = 2;
    localparam int CFG_CLK_LSB    = 0;
    // ------------------------------------------------------------------
    // encodings and reset values
    // ------------------------------------------------------------------
    localparam logic [4:0] CHAN_ALL_ONES  = 5'h1F;
    localparam logic [4:0] CHAN_RESET     = 5'h1F;
    localparam logic [1:0] CLK_BUS        = 2'h0;
    localparam logic [1:0] CLK_BUS_HALF   = 2'h1;
    localparam logic [1:0] CLK_ALTERNATE  = 2'h2;
    localparam logic [1:0] CLK_ASYNC      = 2'h3;
    localparam logic [1:0] DIV_RESET      = 2'h0;
    localparam logic [1:0] MODE_8BIT      = 2'h0;
    localparam logic [1:0] MODE_10BIT     = 2'h2;
    localparam logic [7:0] PIN_DIS_RESET  = 8'h00;
    localparam logic [9:0] RESULT_RESET   = 10'h000;
    localparam logic [9:0] MAX_10BIT      = 10'h3FF;
    localparam logic [9:0] MAX_8BIT       = 10'h0FF;

    typedef enum logic {ST_IDLE, ST_CONV} adcs_state_t;

    // request to the analog core
    typedef struct packed {
        logic        enable;
        logic        start;
        logic        abort;
        logic        tick;
        logic        asyncRun;
        logic        mode10;
        logic [4:0]  channel;
    } adcs_core_req_t;

    // answer from the analog core
    typedef struct packed {
        logic        done;
        logic [10:0] raw;
    } adcs_core_rsp_t;
endpackage

/* File: core/adcs_sequencer.sv */
/*
 * Converter sequencer: register file on classic Wishbone, start logic,
 * clock select and divide, rounding, compare, blocking and pin control.
 * Assumes the analog core answers on ref_clk and that pins, the
 * alternate clock, the asynchronous clock and the trigger are
 * asynchronous to ref_clk.
 */
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
// What this block does
// (RQ1) pin disable 3 bits 7..0 isolate channels 23..16 when set
// (RQ2) set bit forces pin output off and its pullup off
// (RQ3) set bit disables pin input; port read of it returns zero
// (RQ4) converter off in reset and when channel select is all ones
// (RQ5) converter idles at lowest power between conversions
// (RQ6) 10-bit mode rounds 11-bit raw to 10 bits, high and low
// (RQ7) 8-bit mode rounds 9-bit raw to 8 bits, low register only
// (RQ8) result transfer sets complete flag; interrupt if enabled then
// (RQ9) compare enable compares every result, in all modes
// (RQ10) clock select picks bus, half bus, alternate or async; bus at reset
// (RQ11) selected source divided by 1, 2, 4 or 8
// (RQ12) async clock keeps running in wait and stop3 when selected
// (RQ13) trigger select set: rising trigger edge starts a conversion
// (RQ14) trigger edge during a conversion is ignored
// (RQ15) with continuous mode only the first trigger edge counts
// (RQ16) software mode: write to control 1, channel not all ones, starts
// (RQ17) continuous mode restarts after each transfer until aborted
// (RQ18) 10-bit: after high read, before low read, transfers are dropped
// (RQ19) a dropped transfer starts another conversion in any mode
// (RQ20) single, compare on, compare false: stop, no further conversion
// (RQ21) software waits for completion before reading results
// (RQ22) clock select codes 00 bus, 01 half, 10 alternate, 11 async
// (RQ23) divide codes 00 by 1, 01 by 2, 10 by 4, 11 by 8
// (RQ24) mode 00 is 8-bit, 10 is 10-bit; 01 and 11 reserved
// (RQ25) write to control 2, config or compare aborts; results kept
// (RQ26) trigger synchronised before edge detection, each edge once
`timescale 1ns/10ps
module adcs_sequencer (
    input  wire logic                    ref_clk,
    input  wire logic                    rst_b,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [7:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    input  wire logic                    hw_trigger_input,
    input  wire logic                    alternate_clock,
    input  wire logic                    async_conv_clock,
    input  wire logic                    stopMode,
    output adcs_pkg::adcs_core_req_t     coreReq,
    input  wire adcs_pkg::adcs_core_rsp_t coreRsp,
    output logic                         convIrq,
    input  wire logic [7:0]              portOut,
    input  wire logic [7:0]              portOe,
    input  wire logic [7:0]              portPullEn,
    input  wire logic [7:0]              padIn,
    output logic      [7:0]              padOut,
    output logic      [7:0]              padOe,
    output logic      [7:0]              padPullEn,
    output logic      [7:0]              portRead
);
    import adcs_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    adcs_state_t    state, next_state;
    adcs_core_req_t next_coreReq;
    logic        irqEn, contEn, hwSel, cmpEn, cmpGt, conversion_complete_flag, blockPend;
    logic        next_irqEn, next_contEn, next_hwSel, next_cmpEn;
    logic        next_cmpGt, next_conversion_complete_flag, next_blockPend, next_convIrq;
    logic [4:0]  chanSel, next_chanSel;
    logic [1:0]  divSel, modeSel, clkSel;
    logic [1:0]  next_divSel, next_modeSel, next_clkSel;
    logic [9:0]  cmpVal, resVal, next_cmpVal, next_resVal;
    logic [7:0]  pinDis, next_pinDis, next_portRead;
    logic [10:0] syncA, syncB, next_syncA, next_syncB;
    logic [2:0]  syncPrev, next_syncPrev;
    logic [2:0]  divCnt, next_divCnt;
    logic        halfTgl, next_halfTgl;
    logic [31:0] next_wbDat;
    logic        next_wbAck;

    // ------------------------------------------------------------------
    // combinational helpers
    // ------------------------------------------------------------------
    logic        busReq, wrAck, rdAck, chanOk, mode10, hwRise;
    logic        srcTick, kill, go, transfer, pass, blocked, restart;
    logic [2:0]  divMask;
    logic [11:0] sum10;
    logic [9:0]  sum8, rounded, cmpRef, diff;
    logic        cmpCond;

    assign busReq = wb_cyc_i & wb_stb_i;
    assign wrAck  = busReq & wb_ack_o & wb_we_i & wb_sel_i[0];
    assign rdAck  = busReq & wb_ack_o & ~wb_we_i;
    assign chanOk = (chanSel != CHAN_ALL_ONES);
    assign mode10 = (modeSel == MODE_10BIT);
    // edge seen on second stage against its own delayed copy
    assign hwRise = syncB[2] & ~syncPrev[2];
    // pins isolated by pin disable bits
    assign padOut    = portOut;
    assign padOe     = portOe & ~pinDis;                    // see RQ2
    assign padPullEn = portPullEn & ~pinDis;                // see RQ2

    // ------------------------------------------------------------------
    // rounding and compare
    // ------------------------------------------------------------------
    always_comb begin
        sum10 = {1'b0, coreRsp.raw} + 12'h001;
        sum8  = {1'b0, coreRsp.raw[8:0]} + 10'h001;
        if (mode10) begin
            rounded = sum10[11] ? MAX_10BIT : sum10[10:1];  // see RQ6
        end else begin
            rounded = sum8[9] ? MAX_8BIT : {1'b0, sum8[9:1]}; // see RQ7
        end
        cmpRef  = mode10 ? cmpVal : {2'h0, cmpVal[7:0]};
        diff    = rounded - cmpRef;
        cmpCond = cmpGt ? (rounded >= cmpRef) : (rounded < cmpRef);
        pass    = ~cmpEn | cmpCond;                         // see RQ9
        blocked = mode10 & blockPend;                       // see RQ18
    end

    // ------------------------------------------------------------------
    // conversion clock source and divider
    // ------------------------------------------------------------------
    always_comb begin
        unique case (clkSel)                                // see RQ22
            CLK_BUS:       srcTick = 1'b1;
            CLK_BUS_HALF:  srcTick = halfTgl;
            CLK_ALTERNATE: srcTick = syncB[1] & ~syncPrev[1];
            CLK_ASYNC:     srcTick = syncB[0] & ~syncPrev[0];
        endcase
        unique case (divSel)                                // see RQ23
            2'h0: divMask = 3'h0;
            2'h1: divMask = 3'h1;
            2'h2: divMask = 3'h3;
            2'h3: divMask = 3'h7;
        endcase
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_state     = state;
        next_irqEn     = irqEn;
        next_contEn    = contEn;
        next_chanSel   = chanSel;
        next_hwSel     = hwSel;
        next_cmpEn     = cmpEn;
        next_cmpGt     = cmpGt;
        next_divSel    = divSel;
        next_modeSel   = modeSel;
        next_clkSel    = clkSel;
        next_cmpVal    = cmpVal;
        next_resVal    = resVal;
        next_pinDis    = pinDis;
        next_conversion_complete_flag      = conversion_complete_flag;
        next_blockPend = blockPend;
        kill           = 1'b0;
        go             = 1'b0;
        transfer       = 1'b0;
        restart        = 1'b0;
        // synchronisers: pads, trigger, alternate, async clock
        next_syncA     = {padIn, hw_trigger_input, alternate_clock,
                          async_conv_clock};                // see RQ26
        next_syncB     = syncA;
        next_syncPrev  = syncB[2:0];
        next_portRead  = syncB[10:3] & ~pinDis;             // see RQ3
        next_halfTgl   = ~halfTgl;
        next_divCnt    = srcTick ? divCnt + 3'h1 : divCnt;  // see RQ11
        // register writes
        if (wrAck) begin
            unique case (wb_adr_i)
                OFF_STATUS_CONTROL_1: begin
                    next_irqEn   = wb_dat_i[SC1_IRQEN_BIT];
                    next_contEn  = wb_dat_i[SC1_CONT_BIT];
                    next_chanSel = wb_dat_i[4:0];
                    next_conversion_complete_flag    = 1'b0;
                    kill         = 1'b1;
                    go = ~hwSel & (wb_dat_i[4:0] != CHAN_ALL_ONES); // see RQ16
                end
                OFF_STATUS_CONTROL_2: begin
                    next_hwSel = wb_dat_i[SC2_HWSEL_BIT];
                    next_cmpEn = wb_dat_i[SC2_CMPEN_BIT];
                    next_cmpGt = wb_dat_i[SC2_CMPGT_BIT];
                    kill       = 1'b1;                      // see RQ25
                end
                OFF_CONFIGURATION_REG: begin
                    next_divSel  = wb_dat_i[CFG_DIV_LSB +: 2];
                    next_modeSel = wb_dat_i[CFG_MODE_LSB +: 2]; // see RQ24
                    next_clkSel  = wb_dat_i[CFG_CLK_LSB +: 2];  // see RQ10
                    kill         = 1'b1;                    // see RQ25
                end
                OFF_COMPARE_VALUE_HIGH: begin
                    next_cmpVal[9:8] = wb_dat_i[1:0];
                    kill             = 1'b1;                // see RQ25
                end
                OFF_COMPARE_VALUE_LOW: begin
                    next_cmpVal[7:0] = wb_dat_i[7:0];
                    kill             = 1'b1;                // see RQ25
                end
                OFF_ANALOG_PIN_DIS_3: begin
                    next_pinDis = wb_dat_i[7:0];            // see RQ1
                end
                default: begin
                end
            endcase
        end
        // result reads arm and release the overwrite block
        if (rdAck && wb_adr_i == OFF_RESULT_HIGH && mode10) begin
            next_blockPend = 1'b1;                          // see RQ18
        end
        if (rdAck && wb_adr_i == OFF_RESULT_LOW) begin
            next_blockPend = 1'b0;
            next_conversion_complete_flag      = 1'b0;
        end
        // stop without async source, or disabled channel, ends activity
        if ((stopMode && clkSel != CLK_ASYNC) ||
            next_chanSel == CHAN_ALL_ONES) begin
            kill = 1'b1;                                    // see RQ4
            go   = 1'b0;
        end
        // trigger edge only counts while idle
        if (hwSel && hwRise && state == ST_IDLE && chanOk && !kill) begin
            go = 1'b1;                                      // see RQ13 RQ14 RQ15
        end
        if (kill) begin
            next_state = ST_IDLE;
        end
        if (go) begin
            next_state = ST_CONV;
        end else if (!kill && state == ST_CONV && coreRsp.done) begin
            if (pass && !blocked) begin
                transfer = 1'b1;                            // see RQ8
                restart  = contEn;                          // see RQ17
            end else if (!pass) begin
                restart  = contEn;                          // see RQ20
            end else begin
                restart  = 1'b1;                            // see RQ19
            end
            next_state = restart ? ST_CONV : ST_IDLE;       // see RQ5
        end
        if (transfer) begin
            if (mode10) begin
                next_resVal = cmpEn ? diff : rounded;       // see RQ6
            end else begin
                next_resVal[7:0] = cmpEn ? diff[7:0] : rounded[7:0]; // see RQ7
            end
            next_conversion_complete_flag = 1'b1;                               // see RQ8
        end
        // control outputs to the analog core
        next_coreReq.enable   = (next_chanSel != CHAN_ALL_ONES); // see RQ4
        next_coreReq.start    = go | restart;
        next_coreReq.abort    = kill & (state == ST_CONV);
        next_coreReq.tick     = srcTick & ((divCnt & divMask) == divMask);
        next_coreReq.asyncRun = (clkSel == CLK_ASYNC) &&
                                (next_state == ST_CONV);    // see RQ12
        next_coreReq.mode10   = mode10;
        next_coreReq.channel  = next_chanSel;
        next_convIrq          = next_conversion_complete_flag & next_irqEn;     // see RQ8
        // bus answer one cycle after the request
        next_wbAck = busReq & ~wb_ack_o;
        next_wbDat = 32'h0000_0000;
        unique case (wb_adr_i)
            OFF_STATUS_CONTROL_1:
                next_wbDat[7:0] = {conversion_complete_flag, irqEn, contEn, chanSel};
            OFF_STATUS_CONTROL_2:
                next_wbDat[7:0] = {state == ST_CONV, hwSel, cmpEn,
                                   cmpGt, 4'h0};
            OFF_RESULT_HIGH:        next_wbDat[1:0] = resVal[9:8];
            OFF_RESULT_LOW:         next_wbDat[7:0] = resVal[7:0];
            OFF_COMPARE_VALUE_HIGH: next_wbDat[1:0] = cmpVal[9:8];
            OFF_COMPARE_VALUE_LOW:  next_wbDat[7:0] = cmpVal[7:0];
            OFF_CONFIGURATION_REG:
                next_wbDat[7:0] = {1'b0, divSel, 1'b0, modeSel, clkSel};
            OFF_ANALOG_PIN_DIS_3:   next_wbDat[7:0] = pinDis;
            default:                next_wbDat = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state     <= ST_IDLE;
            coreReq   <= '0;
            irqEn     <= 1'b0;
            contEn    <= 1'b0;
            chanSel   <= CHAN_RESET;
            hwSel     <= 1'b0;
            cmpEn     <= 1'b0;
            cmpGt     <= 1'b0;
            divSel    <= DIV_RESET;
            modeSel   <= MODE_8BIT;
            clkSel    <= CLK_BUS;
            cmpVal    <= RESULT_RESET;
            resVal    <= RESULT_RESET;
            pinDis    <= PIN_DIS_RESET;
            conversion_complete_flag      <= 1'b0;
            blockPend <= 1'b0;
            convIrq   <= 1'b0;
            syncA     <= '0;
            syncB     <= '0;
            syncPrev  <= '0;
            portRead  <= '0;
            divCnt    <= '0;
            halfTgl   <= 1'b0;
            wb_ack_o  <= 1'b0;
            wb_dat_o  <= '0;
        end else begin
            state     <= next_state;
            coreReq   <= next_coreReq;
            irqEn     <= next_irqEn;
            contEn    <= next_contEn;
            chanSel   <= next_chanSel;
            hwSel     <= next_hwSel;
            cmpEn     <= next_cmpEn;
            cmpGt     <= next_cmpGt;
            divSel    <= next_divSel;
            modeSel   <= next_modeSel;
            clkSel    <= next_clkSel;
            cmpVal    <= next_cmpVal;
            resVal    <= next_resVal;
            pinDis    <= next_pinDis;
            conversion_complete_flag      <= next_conversion_complete_flag;
            blockPend <= next_blockPend;
            convIrq   <= next_convIrq;
            syncA     <= next_syncA;
            syncB     <= next_syncB;
            syncPrev  <= next_syncPrev;
            portRead  <= next_portRead;
            divCnt    <= next_divCnt;
            halfTgl   <= next_halfTgl;
            wb_ack_o  <= next_wbAck;
            wb_dat_o  <= next_wbDat;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_pin_output_off: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (padOe & pinDis) == 8'h00 && (padPullEn & pinDis) == 8'h00)
        else $error("disabled pin still driven or pulled"); // see RQ2
    a_port_read_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ##1 (portRead & $past(pinDis)) == 8'h00)
        else $error("disabled pin reads nonzero");           // see RQ3
    a_no_start_off: assert property (@(posedge ref_clk) disable iff (!rst_b)
        next_chanSel == CHAN_ALL_ONES |=> !coreReq.start && state == ST_IDLE)
        else $error("conversion started while disabled");    // see RQ4
    a_flag_on_xfer: assert property (@(posedge ref_clk) disable iff (!rst_b)
        transfer |=> conversion_complete_flag && (convIrq == irqEn))
        else $error("transfer did not set flag or irq");     // see RQ8
    a_sw_start_go: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wrAck && wb_adr_i == OFF_STATUS_CONTROL_1 && !hwSel && !stopMode
        && chanOk && wb_dat_i[4:0] != CHAN_ALL_ONES
        |=> coreReq.start && state == ST_CONV)
        else $error("software write did not start");         // see RQ16
    a_hw_edge_drop: assert property (@(posedge ref_clk) disable iff (!rst_b)
        hwRise && state == ST_CONV && !wrAck && !coreRsp.done
        |=> !coreReq.start)
        else $error("trigger edge restarted conversion");    // see RQ14
    a_block_keeps: assert property (@(posedge ref_clk) disable iff (!rst_b)
        state == ST_CONV && coreRsp.done && blocked && pass && !kill && !go
        |=> $stable(resVal) && coreReq.start)
        else $error("blocked result overwrote or stopped");  // see RQ18
    a_abort_keeps: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wrAck && wb_adr_i == OFF_CONFIGURATION_REG && state == ST_CONV
        |=> state == ST_IDLE && $stable(resVal) && coreReq.abort)
        else $error("config write did not abort cleanly");   // see RQ25
    a_single_stop: assert property (@(posedge ref_clk) disable iff (!rst_b)
        state == ST_CONV && coreRsp.done && cmpEn && !cmpCond && !contEn
        && !kill && !go |=> state == ST_IDLE && !coreReq.start)
        else $error("false compare single did not stop");    // see RQ20
endmodule
